// >>> hw/lmu_i2c_gpio.sv
// Overview of operation
// - Setup bits 2:0 set pin direction: 0 input, 1 output.
// - Output pins drive the level held in the level register.
// - PWM select bit forces pin zero to be the PWM input.
// - Only pin zero has the PWM function; others are plain I/O.
// - Reading the level register returns live pin levels.
// - SDA changes only while SCL is low, except START and STOP.
// - START is SDA falling with SCL high; STOP is SDA rising.
// - Bus is busy from START until the next STOP.
// - Repeated START is handled exactly like a first START.
// - Bytes are eight bits, MSB first, then one acknowledge bit.
// - On the ninth pulse the sender releases SDA, receiver pulls low.
// - Addressed receivers acknowledge every byte received.
// - First byte is address 59H plus direction bit, 0 write.
// - In a write, byte two is register address, byte three data.
// - Writes take effect at SCL rise of each data byte's acknowledge.
// - PWM input is active high.
`timescale 1ns/10ps
`default_nettype none
`include "lmu_i2c_regs.svh"

module lmu_i2c_gpio
	import lmu_i2c_pkg::*;
(
	input wire logic clock,
	input wire logic srst,
	input wire logic extResetN,
	input wire logic scl,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic [2:0] pinIn,
	output logic [2:0] pinOut,
	output logic [2:0] pinOe,
	output logic pwmIn,
	output logic busBusy
);
	import lmu_i2c_pkg::*;

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	// All pins cross into the clock domain through two flops each.
	logic [5:0] meta_r;
	logic [5:0] sync_r;
	logic sclD_r;
	logic sdaD_r;
	logic rstSync_r;

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			meta_r <= 6'h3F;
			sync_r <= 6'h3F;
		end
		else
		begin
			meta_r <= {extResetN, pinIn, sdaIn, scl};
			sync_r <= meta_r;
		end
	end

	logic sclS;
	logic sdaS;
	logic [2:0] pinS;
	logic extRst;
	assign sclS = sync_r[0];
	assign sdaS = sync_r[1];
	assign pinS = sync_r[4:2];
	assign extRst = ~sync_r[5];

	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			sclD_r <= 1'b1;
			sdaD_r <= 1'b1;
			rstSync_r <= 1'b0;
		end
		else
		begin
			sclD_r <= sclS;
			sdaD_r <= sdaS;
			rstSync_r <= extRst;
		end
	end

	logic anyRst;
	assign anyRst = srst | rstSync_r;

	// ----------------------------------------------------------------
	// Edge and condition detection
	// ----------------------------------------------------------------
	// Edges compare the synchronised level with its one-cycle copy.
	// The copies reset high so that no false edge follows reset.

	logic sclRise;
	logic sclFall;
	logic startCond;
	logic stopCond;
	assign sclRise = sclS & ~sclD_r;
	assign sclFall = ~sclS & sclD_r;
	assign startCond = sclS & sclD_r & sdaD_r & ~sdaS;
	assign stopCond = sclS & sclD_r & ~sdaD_r & sdaS;

	// ----------------------------------------------------------------
	// Bus occupancy
	// ----------------------------------------------------------------
	logic busy_r;

	always_ff @(posedge clock)
	begin
		if (anyRst)
			busy_r <= 1'b0;
		else if (startCond)
			busy_r <= 1'b1;
		else if (stopCond)
			busy_r <= 1'b0;
	end

	assign busBusy = busy_r;

	// ----------------------------------------------------------------
	// Serial engine
	// ----------------------------------------------------------------
	lmu_phase_e phase_r;
	logic [3:0] bitCnt_r;
	logic [7:0] shift_r;
	logic [7:0] regAddr_r;
	logic ackPhase_r;
	logic ackDrive_r;
	logic txDrive_r;
	logic txBit_r;
	logic mNack_r;
	logic [7:0] setup_r;
	logic [7:0] level_r;
	logic wrStrobe;
	logic [7:0] readVal;

	// ----------------------------------------------------------------
	// Read value
	// ----------------------------------------------------------------
	// Unknown register addresses read as zero.

	// Pin levels are live, so the read value reflects the pin, not the latch.
	always_comb
	begin
		readVal = 8'h00;
		if (regAddr_r == `LMU_REG_PIN_SETUP)
			readVal = setup_r;
		else if (regAddr_r == `LMU_REG_PIN_LEVEL)
			readVal = {5'h00, pinS};
	end

	assign wrStrobe = sclRise && ackPhase_r && ackDrive_r
		&& phase_r == ST_DATA;

	always_ff @(posedge clock)
	begin
		if (anyRst || stopCond)
		begin
			phase_r <= ST_IDLE;
			bitCnt_r <= 4'h0;
			shift_r <= 8'h00;
			ackPhase_r <= 1'b0;
			ackDrive_r <= 1'b0;
			txDrive_r <= 1'b0;
			txBit_r <= 1'b1;
			mNack_r <= 1'b0;
		end
		else if (startCond)
		begin
			phase_r <= ST_ADDR;
			bitCnt_r <= 4'h0;
			ackPhase_r <= 1'b0;
			ackDrive_r <= 1'b0;
			txDrive_r <= 1'b0;
			mNack_r <= 1'b0;
		end
		else if (sclRise && phase_r != ST_IDLE && phase_r != ST_IGNORE)
		begin
			if (ackPhase_r)
			begin
				if (phase_r == ST_SEND)
					mNack_r <= sdaS;
			end
			else if (phase_r != ST_SEND)
			begin
				shift_r <= {shift_r[6:0], sdaS};
				bitCnt_r <= bitCnt_r + 4'h1;
			end
			else
				bitCnt_r <= bitCnt_r + 4'h1;
		end
		else if (sclFall && phase_r != ST_IDLE && phase_r != ST_IGNORE)
		begin
			if (ackPhase_r)
			begin
				// Ninth pulse ends: choose next phase and drop the acknowledge drive; a read then drives the next MSB unless the master sent NACK.
				ackPhase_r <= 1'b0;
				ackDrive_r <= 1'b0;
				bitCnt_r <= 4'h0;
				unique case (phase_r)
					ST_ADDR:
					begin
						if (shift_r[0])
						begin
							phase_r <= ST_SEND;
							shift_r <= readVal;
							txDrive_r <= ~readVal[7];
							txBit_r <= readVal[7];
						end
						else
							phase_r <= ST_REG;
					end
					ST_REG:
						phase_r <= ST_DATA;
					ST_DATA:
						phase_r <= ST_DATA;
					ST_SEND:
					begin
						if (mNack_r)
						begin
							phase_r <= ST_IGNORE;
							txDrive_r <= 1'b0;
						end
						else
						begin
							shift_r <= readVal;
							txDrive_r <= ~readVal[7];
							txBit_r <= readVal[7];
						end
					end
					ST_IDLE, ST_IGNORE:
						phase_r <= phase_r;
				endcase
			end
			else if (bitCnt_r == 4'h8)
			begin
				ackPhase_r <= 1'b1;
				txDrive_r <= 1'b0;
				if (phase_r == ST_ADDR)
				begin
					if (shift_r[7:1] == `LMU_SLAVE_ADDR)
						ackDrive_r <= 1'b1;
					else
					begin
						phase_r <= ST_IGNORE;
						ackPhase_r <= 1'b0;
					end
				end
				else if (phase_r != ST_SEND)
					ackDrive_r <= 1'b1;
			end
			else if (phase_r == ST_SEND)
			begin
				shift_r <= {shift_r[6:0], 1'b0};
				txDrive_r <= ~shift_r[6];
				txBit_r <= shift_r[6];
			end
		end
	end

	// ----------------------------------------------------------------
	// Register address latch
	// ----------------------------------------------------------------
	// A read relies on the address left here by the preceding write.

	// Register address is latched when the second byte completes.
	always_ff @(posedge clock)
	begin
		if (anyRst)
			regAddr_r <= 8'h00;
		else if (sclFall && !ackPhase_r && bitCnt_r == 4'h8
			&& phase_r == ST_REG)
			regAddr_r <= shift_r;
	end

	// ----------------------------------------------------------------
	// SDA drive
	// ----------------------------------------------------------------
	// Drive is set only after a seen SCL fall, so it never starts in the high phase; START, STOP and reset clear it.

	// SDA is open drain: drive low only, release otherwise.
	assign sdaOut = 1'b0;
	assign sdaOe = ackDrive_r | txDrive_r;

	// ----------------------------------------------------------------
	// Registers and pins
	// ----------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (anyRst)
		begin
			setup_r <= `LMU_SETUP_RESET;
			level_r <= `LMU_LEVEL_RESET;
		end
		else if (wrStrobe)
		begin
			if (regAddr_r == `LMU_REG_PIN_SETUP)
				setup_r <= {3'h0, shift_r[`LMU_PWM_SEL_BIT], 1'b0,
					shift_r[`LMU_DIR_MSB:0]};
			else if (regAddr_r == `LMU_REG_PIN_LEVEL)
				level_r <= {5'h00, shift_r[2:0]};
		end
	end

	// ----------------------------------------------------------------
	// Pin drivers
	// ----------------------------------------------------------------
	// Input pins still read back through the synchronisers.

	lmu_pins_s pins;
	genvar gi;
	generate
		for (gi = 0; gi < `LMU_PIN_COUNT; gi++)
		begin : g_pin
			if (gi == 0)
			begin : g_pwm
				assign pins.oe[gi] = setup_r[gi]
					& ~setup_r[`LMU_PWM_SEL_BIT];
			end
			else
			begin : g_io
				assign pins.oe[gi] = setup_r[gi];
			end
			assign pins.out[gi] = level_r[gi];
		end
	endgenerate
	assign pins.in = pinS;

	assign pinOut = pins.out;
	assign pinOe = pins.oe;
	// ----------------------------------------------------------------
	// PWM input
	// ----------------------------------------------------------------
	// The select bit gates the input, so an idle pin cannot light the LED.

	// High level on pin zero means the LED is on.
	assign pwmIn = setup_r[`LMU_PWM_SEL_BIT] & pins.in[0];
endmodule

`default_nettype wire

// >>> hw/lmu_i2c_pkg.sv
package lmu_i2c_pkg;
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_REG,
		ST_DATA,
		ST_SEND,
		ST_IGNORE
	} lmu_phase_e;

	typedef struct packed {
		logic [2:0] in;
		logic [2:0] out;
		logic [2:0] oe;
	} lmu_pins_s;
endpackage

// >>> hw/lmu_i2c_regs.svh
`ifndef LMU_I2C_REGS_SVH
`define LMU_I2C_REGS_SVH

`define LMU_SLAVE_ADDR 7'h59
`define LMU_REG_PIN_SETUP 8'h06
`define LMU_REG_PIN_LEVEL 8'h07
`define LMU_PWM_SEL_BIT 4
`define LMU_DIR_MSB 2
`define LMU_PIN_COUNT 3
`define LMU_SETUP_RESET 8'h00
`define LMU_LEVEL_RESET 8'h00

`endif

// >>> verif/lmu_i2c_gpio_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "lmu_i2c_regs.svh"
module lmu_i2c_gpio_bench;
	logic clock = 1'b0;
	logic srst = 1'b1;
	logic extResetN = 1'b1;
	logic [2:0] ext = 3'h0;
	logic scl, mLow, sdaOut, sdaOe, pwmIn, busBusy;
	logic [2:0] pinOut, pinOe;
	// Open-drain line with pull-up; pads show the driven level when enabled.
	wire logic sda = ~(mLow | sdaOe);
	wire logic [2:0] pinIn = (pinOe & pinOut) | (~pinOe & ext);
	int failures = 0;
	int cmp_count = 0;
	always #20 clock = ~clock;
	lmu_i2c_gpio lmu_i2c_gpio_inst (.clock(clock), .srst(srst),
		.extResetN(extResetN), .scl(scl), .sdaIn(sda), .sdaOut(sdaOut),
		.sdaOe(sdaOe), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
		.pwmIn(pwmIn), .busBusy(busBusy));
	lmu_i2c_master lmu_i2c_master_inst (.clock(clock), .sda(sda), .scl(scl),
		.sdaLow(mLow));
	task automatic check(input string n, input logic [7:0] v, input logic [7:0] e);
		cmp_count++;
		if (v !== e)
		begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, v);
		end
	endtask
	task automatic test_done();
		if (failures == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	function automatic logic [2:0] eOe(input logic [7:0] s);
		return s[2:0] & {2'b11, ~s[4]};
	endfunction
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [6:0] dev);
		logic [7:0] q;
		logic ack;
		logic [7:0] nak;
		nak = {7'h0, dev != `LMU_SLAVE_ADDR};
		lmu_i2c_master_inst.start();
		check("busy", {7'h0, busBusy}, 8'h01);
		lmu_i2c_master_inst.xfer({dev, 1'b0}, 1'b1, q, ack);
		check("addr ack", {7'h0, ack}, nak);
		lmu_i2c_master_inst.xfer(a, 1'b1, q, ack);
		check("reg ack", {7'h0, ack}, nak);
		lmu_i2c_master_inst.xfer(d, 1'b1, q, ack);
		check("data ack", {7'h0, ack}, nak);
		lmu_i2c_master_inst.stop();
		check("free", {7'h0, busBusy}, 8'h00);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] q);
		logic ack;
		logic [7:0] j;
		lmu_i2c_master_inst.start();
		lmu_i2c_master_inst.xfer(8'hB2, 1'b1, j, ack);
		lmu_i2c_master_inst.xfer(a, 1'b1, j, ack);
		lmu_i2c_master_inst.start();
		lmu_i2c_master_inst.xfer(8'hB3, 1'b1, j, ack);
		check("rd ack", {7'h0, ack}, 8'h00);
		lmu_i2c_master_inst.xfer(8'hFF, 1'b1, q, ack);
		lmu_i2c_master_inst.stop();
	endtask
	initial
	begin
		logic [7:0] s, l, q;
		s = $urandom(32'hC59FD552);
		repeat (12) @(posedge clock);
		srst <= 1'b0;
		repeat (4) @(posedge clock);
		rd(`LMU_REG_PIN_SETUP, q);
		check("setup rst", q, `LMU_SETUP_RESET);
		for (int i = 0; i < 8; i++)
		begin
			s = (i < 2) ? {3'h0, i[0], 4'hF} : 8'($urandom);
			l = 8'($urandom);
			ext <= 3'($urandom);
			wr(`LMU_REG_PIN_SETUP, s, `LMU_SLAVE_ADDR);
			wr(`LMU_REG_PIN_LEVEL, l, `LMU_SLAVE_ADDR);
			check("oe", {5'h0, pinOe}, {5'h0, eOe(s)});
			check("out", {5'h0, pinOut & pinOe}, {5'h0, l[2:0] & eOe(s)});
			check("pwm", {7'h0, pwmIn}, {7'h0, s[4] & ext[0]});
			rd(`LMU_REG_PIN_SETUP, q);
			check("setup", q, s & 8'h17);
		end
		wr(`LMU_REG_PIN_LEVEL, ~l, 7'h5A);
		rd(`LMU_REG_PIN_LEVEL, q);
		check("level", q, {5'h0, (eOe(s) & l[2:0]) | (~eOe(s) & ext)});
		extResetN <= 1'b0;
		repeat (6) @(posedge clock);
		extResetN <= 1'b1;
		repeat (4) @(posedge clock);
		check("ext rst", {5'h0, pinOe}, 8'h00);
		test_done();
	end
endmodule
bind lmu_i2c_gpio lmu_i2c_props lmu_i2c_props_inst (.clock(clock),
	.srst(srst), .extResetN(extResetN), .scl(scl), .sdaIn(sdaIn),
	.sdaOut(sdaOut), .sdaOe(sdaOe), .pinIn(pinIn), .pinOut(pinOut),
	.pinOe(pinOe), .pwmIn(pwmIn), .busBusy(busBusy));
`default_nettype wire

// >>> verif/lmu_i2c_master.sv
`timescale 1ns/10ps
`default_nettype none
module lmu_i2c_master
(
	input wire logic clock,
	input wire logic sda,
	output logic scl,
	output logic sdaLow
);
	initial
	begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	// One sequence serves first and repeated START alike.
	task automatic start();
		tick(2);
		sdaLow <= 1'b0;
		tick(2);
		scl <= 1'b1;
		tick(4);
		sdaLow <= 1'b1;
		tick(4);
		scl <= 1'b0;
	endtask
	task automatic stop();
		tick(2);
		sdaLow <= 1'b1;
		tick(2);
		scl <= 1'b1;
		tick(4);
		sdaLow <= 1'b0;
		tick(6);
	endtask
	// Eight bits then the ninth pulse, eight clocks each.
	task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic ack);
		logic [8:0] w;
		w = {d, ai};
		for (int i = 8; i >= 0; i--)
		begin
			tick(2);
			sdaLow <= ~w[i];
			tick(2);
			scl <= 1'b1;
			tick(2);
			@(negedge clock);
			w[i] = sda;
			tick(2);
			scl <= 1'b0;
		end
		q = w[8:1];
		ack = w[0];
	endtask
endmodule
`default_nettype wire

// >>> verif/lmu_i2c_props.sv
`timescale 1ns/10ps
`default_nettype none
module lmu_i2c_props
(
	input wire logic clock,
	input wire logic srst,
	input wire logic extResetN,
	input wire logic scl,
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic [2:0] pinIn,
	input wire logic [2:0] pinOut,
	input wire logic [2:0] pinOe,
	input wire logic pwmIn,
	input wire logic busBusy
);
	default clocking @(posedge clock); endclocking
	default disable iff (srst || !extResetN);
	a_sda_open_drain: assert property (!sdaOut)
		else $error("sdaOut high");
	a_sda_scl_low: assert property ($changed(sdaOe) |-> !scl)
		else $error("SDA moved with SCL high");
	a_start_busy: assert property (scl && $fell(sdaIn) |-> ##[1:4] busBusy)
		else $error("START missed");
	a_stop_free: assert property (scl && $rose(sdaIn) |-> ##[1:4] !busBusy)
		else $error("STOP missed");
	a_idle_quiet: assert property (!busBusy |-> !sdaOe)
		else $error("drive while free");
	a_regs_idle: assert property (!busBusy |=> $stable(pinOe) && $stable(pinOut))
		else $error("register moved while free");
	a_pwm_pin0_in: assert property (pwmIn |-> !pinOe[0])
		else $error("pin0 driven in PWM mode");
	a_pwm_level: assert property (pwmIn |-> $past(pinIn[0]) || $past(pinIn[0], 2) || $past(pinIn[0], 3))
		else $error("pwmIn not from pin0");
	a_ack_stands: assert property ($rose(sdaOe) |-> sdaOe[*4])
		else $error("SDA drive too short");
endmodule
`default_nettype wire
